// ### gbit_pcs_tx_map.vh
`ifndef GBIT_PCS_TX_MAP_VH
`define GBIT_PCS_TX_MAP_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CTRL_OFS        12'h000
`define STATUS_OFS      12'h004
`define SUB_TBL_BASE    12'h400
`define NORM_TBL_BASE   12'h800
// ****************************************
// control fields
// ****************************************
`define CTRL_MODE_LSB   0
`define CTRL_MASTER_BIT 2
`define CTRL_LPI_BIT    3
`define CTRL_RCVR_BIT   4
`define CTRL_UPD_BIT    5
`define CTRL_RESET      8'h04
// ****************************************
// transmit modes and row kinds
// ****************************************
`define MODE_SEND_N     2'h0
`define MODE_SEND_I     2'h1
`define MODE_SEND_Z     2'h2
`define ROW_NORMAL      3'h0
`define ROW_XMT_ERR     3'h1
`define ROW_CSRESET     3'h2
`define ROW_CSEXT       3'h3
`define ROW_CSEXT_ERR   3'h4
// ****************************************
// scrambler, extension, persistence, bus responses
// ****************************************
`define SCR_SEED        33'h0_0000_0001
`define TAP_MASTER      12
`define TAP_SLAVE       19
`define EXT_OCTET       8'h0F
`define EXT_HOLD_CNT    2'h3
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ### gbit_pcs_tx_trellis_mapper.v
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "gbit_pcs_tx_map.vh"

module gbit_pcs_tx_trellis_mapper (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // gmii transmit side
  input  wire        txEnable,
  input  wire        txError,
  input  wire [7:0]  txData,
  // pma side
  output reg  [8:0]  encodedWord_r,
  output reg  [2:0]  rowKind_r,
  output reg  [2:0]  pairASymbol_r,
  output reg  [2:0]  pairBSymbol_r,
  output reg  [2:0]  pairCSymbol_r,
  output reg  [2:0]  pairDSymbol_r,
  output reg         extFaultHold_r,
  // axi4-lite write
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ****************************************
  // helpers
  // ****************************************
  function [15:0] mergeStrb;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0]  strb;
    begin
      mergeStrb = {strb[1] ? newVal[15:8] : oldVal[15:8],
                   strb[0] ? newVal[7:0]  : oldVal[7:0]};
    end
  endfunction

  function [1:0] decodeAddr;  // 0 unmapped, 1 ctrl, 2 status, 3 table
    input [11:0] a;
    begin
      if (a[1:0] != 2'h0)
        decodeAddr = 2'h0;
      else if (a == `CTRL_OFS)
        decodeAddr = 2'h1;
      else if (a == `STATUS_OFS)
        decodeAddr = 2'h2;
      else if (a[11] || (a[11:7] == `SUB_TBL_BASE >> 7))
        decodeAddr = 2'h3;
      else
        decodeAddr = 2'h0;
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg  [11:0] normTbl [0:511];
  reg  [11:0] subTbl  [0:31];
  reg  [7:0]  ctrl_r;
  reg  [32:0] scr_r;
  reg         parity_r;
  reg  [3:0]  syPrev_r;
  reg  [2:0]  cs_r;
  reg  [3:0]  enHist_r;
  reg  [2:0]  errHist_r;
  reg  [1:0]  holdCnt_r;
  reg  [11:0] awAddr_r;
  reg         awHave_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHave_r;

  wire [1:0]  txMode   = ctrl_r[`CTRL_MODE_LSB +: 2];
  wire        master   = ctrl_r[`CTRL_MASTER_BIT];
  wire        lpiReq   = ctrl_r[`CTRL_LPI_BIT];
  wire        rcvrOk   = ctrl_r[`CTRL_RCVR_BIT];
  wire        updDone  = ctrl_r[`CTRL_UPD_BIT];
  wire        sendZ    = (txMode == `MODE_SEND_Z);
  wire        en1      = enHist_r[0];
  wire        en2      = enHist_r[1];
  wire        isExt    = (txData == `EXT_OCTET);

  // ****************************************
  // scrambler derived bits
  // ****************************************
  wire        fbBit = scr_r[32] ^ (master ? scr_r[`TAP_MASTER] : scr_r[`TAP_SLAVE]);
  wire [3:0]  sy = {scr_r[9] ^ scr_r[14] ^ scr_r[19] ^ scr_r[24],
                    scr_r[6] ^ scr_r[16], scr_r[3] ^ scr_r[8], scr_r[0]};
  wire [3:0]  sx = {scr_r[13] ^ scr_r[15] ^ scr_r[18] ^ scr_r[20] ^
                    scr_r[23] ^ scr_r[25] ^ scr_r[28] ^ scr_r[30],
                    scr_r[10] ^ scr_r[12] ^ scr_r[20] ^ scr_r[22],
                    scr_r[7] ^ scr_r[9] ^ scr_r[12] ^ scr_r[14],
                    scr_r[4] ^ scr_r[6]};

  // ****************************************
  // encoder
  // ****************************************
  reg  [7:0]  sc;
  reg  [8:0]  sd;
  reg  [2:0]  csNxt;
  reg         csReset;
  reg         cext;
  reg         cextErr;
  reg  [2:0]  rowKind;
  reg  [1:0]  holdNxt;
  reg  [11:0] quartet;

  always @* begin
    sc[7:4] = en2 ? sx : 4'h0;
    if (sendZ)
      sc[3:1] = 3'h0;
    else if (!parity_r)
      sc[3:1] = sy[3:1];
    else
      sc[3:1] = ~syPrev_r[3:1];
    sc[0] = sendZ ? 1'b0 : sy[0];
    csReset = en2 & ~txEnable;
    cext    = (~txEnable & isExt) ? txError : 1'b0;
    cextErr = (~txEnable & ~isExt & ~lpiReq) ? txError : 1'b0;
    if (!csReset && en2)
      sd[7:6] = sc[7:6] ^ txData[7:6];
    else if (csReset)
      sd[7:6] = cs_r[1:0];
    else
      sd[7:6] = sc[7:6];
    sd[5:4] = en2 ? sc[5:4] ^ txData[5:4] : sc[5:4];
    if (en2)
      sd[3] = sc[3] ^ txData[3];
    else
      sd[3] = sc[3] ^ (lpiReq & ~sendZ);
    if (en2)
      sd[2] = sc[2] ^ txData[2];
    else
      sd[2] = sc[2] ^ (rcvrOk & ~sendZ);
    if (en2)
      sd[1] = sc[1] ^ txData[1];
    else if (updDone && !sendZ)
      sd[1] = ~sc[1];
    else
      sd[1] = sc[1] ^ cextErr;
    sd[0] = en2 ? sc[0] ^ txData[0] : sc[0] ^ cextErr;
    csNxt[0] = cs_r[2];
    csNxt[1] = en2 ? sd[6] ^ cs_r[0] : 1'b0;
    csNxt[2] = en2 ? sd[7] ^ cs_r[1] : 1'b0;
    sd[8] = csNxt[0];
    holdNxt = (holdCnt_r != 2'h0) ? holdCnt_r - 2'h1 : 2'h0;
    if (txError && txEnable && en2)
      rowKind = `ROW_XMT_ERR;
    else if (csReset && holdCnt_r != 2'h0)
      rowKind = `ROW_CSEXT_ERR;
    else if (csReset && !txError)
      rowKind = `ROW_CSRESET;
    else if (csReset)
      rowKind = isExt ? `ROW_CSEXT : `ROW_CSEXT_ERR;
    else
      rowKind = `ROW_NORMAL;
    if (csReset && en1 && rowKind == `ROW_CSEXT_ERR)
      holdNxt = `EXT_HOLD_CNT;
    // column is bits 6,7,8 read left to right, row is bits 5:0
    if (rowKind == `ROW_NORMAL)
      quartet = normTbl[{sd[6], sd[7], sd[8], sd[5:0]}];
    else
      quartet = subTbl[{rowKind[1:0] - 2'h1, sd[6], sd[7], sd[8]}];
  end

  // ****************************************
  // datapath registers
  // ****************************************
  always @(posedge core_clk) begin
    if (!resetn) begin
      scr_r          <= `SCR_SEED;
      parity_r       <= 1'b0;
      syPrev_r       <= 4'h0;
      cs_r           <= 3'h0;
      enHist_r       <= 4'h0;
      errHist_r      <= 3'h0;
      holdCnt_r      <= 2'h0;
      encodedWord_r  <= 9'h000;
      rowKind_r      <= `ROW_NORMAL;
      pairASymbol_r  <= 3'h0;
      pairBSymbol_r  <= 3'h0;
      pairCSymbol_r  <= 3'h0;
      pairDSymbol_r  <= 3'h0;
      extFaultHold_r <= 1'b0;
    end else begin
      scr_r          <= {scr_r[31:0], fbBit};
      parity_r       <= ~parity_r;
      syPrev_r       <= sy;
      cs_r           <= csNxt;
      enHist_r       <= {enHist_r[2:0], txEnable};
      errHist_r      <= {errHist_r[1:0], txError};
      holdCnt_r      <= holdNxt;
      encodedWord_r  <= sd;
      rowKind_r      <= rowKind;
      pairASymbol_r  <= quartet[11:9];
      pairBSymbol_r  <= quartet[8:6];
      pairCSymbol_r  <= quartet[5:3];
      pairDSymbol_r  <= quartet[2:0];
      // old count kept in so the flag also covers the last delimiter octet
      extFaultHold_r <= (holdNxt != 2'h0) || (holdCnt_r != 2'h0);
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  // address and data are latched apart so either may come first
  wire        doWrite = awHave_r & wHave_r & ~s_axi_bvalid;
  wire [1:0]  wSel    = decodeAddr(awAddr_r);
  wire [1:0]  rSel    = decodeAddr(s_axi_araddr);
  wire [8:0]  wIdx    = awAddr_r[10:2];
  wire [8:0]  rIdx    = s_axi_araddr[10:2];
  wire [15:0] ctrlMrg = mergeStrb({8'h00, ctrl_r}, wData_r[15:0], wStrb_r[1:0]);
  wire [15:0] normMrg = mergeStrb({4'h0, normTbl[wIdx]}, wData_r[15:0], wStrb_r[1:0]);
  wire [15:0] subMrg  = mergeStrb({4'h0, subTbl[wIdx[4:0]]}, wData_r[15:0], wStrb_r[1:0]);
  reg  [31:0] rdData;

  always @* begin
    case (rSel)
      2'h1:    rdData = {24'h00_0000, ctrl_r};
      2'h2:    rdData = {16'h0000, extFaultHold_r, rowKind_r,
                         encodedWord_r, cs_r};
      2'h3:    rdData = {20'h0_0000, s_axi_araddr[11] ? normTbl[rIdx]
                                                     : subTbl[rIdx[4:0]]};
      default: rdData = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (doWrite && wSel == 2'h3) begin
      if (awAddr_r[11])
        normTbl[wIdx] <= normMrg[11:0];
      else
        subTbl[wIdx[4:0]] <= subMrg[11:0];
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_r        <= `CTRL_RESET;
      awAddr_r      <= 12'h000;
      awHave_r      <= 1'b0;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
      wHave_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~awHave_r & ~s_axi_awready;
      s_axi_wready  <= s_axi_wvalid & ~wHave_r & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
      if (doWrite) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wSel == 2'h0 || wSel == 2'h2) ? `RESP_SLVERR
                                                       : `RESP_OKAY;
        if (wSel == 2'h1)
          ctrl_r <= ctrlMrg[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdData;
        s_axi_rresp  <= (rSel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // gbit_pcs_tx_trellis_mapper

// ### gbit_pcs_tx_trellis_mapper_asserts.sv
`timescale 1ns/10ps
`include "gbit_pcs_tx_map.vh"
module gbit_pcs_tx_trellis_mapper_checker (
  // clock and reset
  input wire       core_clk,
  input wire       resetn,
  // stream
  input wire       txEnable,
  input wire       txError,
  input wire [7:0] txData,
  input wire [8:0] encodedWord_r,
  input wire [2:0] rowKind_r,
  input wire       extFaultHold_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ****************
  // row selection, hold flag, state flush and reset clear
  // ****************
  a_xmt_err_row: assert property (txEnable && $past(txEnable, 2) && txError
    |=> rowKind_r == `ROW_XMT_ERR) else $error("error row not used");
  a_clean_reset: assert property (!txEnable && $past(txEnable, 2) && !txError
    && rowKind_r != `ROW_CSEXT_ERR |=> rowKind_r == `ROW_CSRESET) else $error("reset row missing");
  a_ext_row: assert property (!txEnable && $past(txEnable, 2) && txError
    && txData == `EXT_OCTET && rowKind_r != `ROW_CSEXT_ERR |=> rowKind_r == `ROW_CSEXT)
    else $error("extend row missing");
  a_ext_err_keep: assert property (!txEnable && $past(txEnable) && $past(txEnable, 2)
    && txError && txData != `EXT_OCTET |=> rowKind_r == `ROW_CSEXT_ERR [*2])
    else $error("extend error not kept");
  a_fault_hold: assert property (!txEnable && $past(txEnable) && $past(txEnable, 2)
    && txError && txData != `EXT_OCTET |=> extFaultHold_r [*4]) else $error("hold flag low");
  a_idle_row: assert property (!$past(txEnable, 2) |=> rowKind_r == `ROW_NORMAL)
    else $error("substitution outside frame end");
  a_state_flush: assert property (!$past(txEnable, 2) && !$past(txEnable, 3)
    |=> !encodedWord_r[8]) else $error("state bit left set");
  a_reset_clear: assert property ($rose(resetn) |-> rowKind_r == `ROW_NORMAL
    && encodedWord_r == 9'h000 && !extFaultHold_r) else $error("outputs not cleared");
endmodule // gbit_pcs_tx_trellis_mapper_checker

bind gbit_pcs_tx_trellis_mapper gbit_pcs_tx_trellis_mapper_checker
  u_gbit_pcs_tx_trellis_mapper_checker (.core_clk, .resetn, .txEnable, .txError, .txData,
  .encodedWord_r, .rowKind_r, .extFaultHold_r);

// ### gmii_source.sv
`timescale 1ns/10ps
module gmii_source (
  // clock and control
  input  wire       core_clk,
  input  wire       run,
  // gmii transmit
  output reg        txEnable = 1'b0,
  output reg        txError  = 1'b0,
  output reg  [7:0] txData   = 8'h00
);
  integer seed = 32'h8fa5;
  integer left = 0;
  // bursts and gaps of 3 to 10 octets: both reset octets always land in a gap
  always @(posedge core_clk) begin
    if (!run) begin
      txEnable <= 1'b0;
      txError  <= 1'b0;
      left = 0;
    end else begin
      if (left == 0) begin
        txEnable <= !txEnable;
        left = 2 + ($random(seed) & 7);
      end else begin
        left = left - 1;
      end
      txError <= (($random(seed) & 3) == 0);
      txData  <= ($random(seed) & 1) ? 8'h0F : 8'($random(seed));
    end
  end
endmodule // gmii_source

// ### gbit_pcs_tx_trellis_mapper_test.sv
`timescale 1ns/10ps
`include "gbit_pcs_tx_map.vh"
module gbit_pcs_tx_trellis_mapper_test;
  typedef struct packed {logic [2:0] k; logic known; logic h; logic [8:0] m; logic [8:0] w;} note_t;
  reg         core_clk = 1'b0;
  reg         resetn = 1'b0;
  reg         run = 1'b0;
  reg         chk = 1'b0;
  reg  [7:0]  ctrlVal = 8'h04;
  reg  [11:0] awaddr = 12'h000;
  reg  [11:0] araddr = 12'h000;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  wire        txEnable, txError, awready, wready, bvalid, arready, rvalid, hold;
  wire [7:0]  txData;
  wire [8:0]  word;
  wire [2:0]  kind, symA, symB, symC, symD;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] sym = {symA, symB, symC, symD};
  integer     errorCnt = 0;
  integer     nCompared = 0;
  integer     t, j, hc;
  reg         e1, e2, e3, e4, persist, csr, ce, sz;
  note_t      nt, got;
  note_t      notes[$];
  reg  [7:0]  modes [0:4] = '{8'h06, 8'h3E, 8'h04, 8'h01, 8'h02};

  gmii_source u_gmii_source (.core_clk, .run, .txEnable, .txError, .txData);
  gbit_pcs_tx_trellis_mapper u_gbit_pcs_tx_trellis_mapper (.core_clk, .resetn, .txEnable,
    .txError, .txData, .encodedWord_r(word), .rowKind_r(kind), .pairASymbol_r(symA),
    .pairBSymbol_r(symB), .pairCSymbol_r(symC), .pairDSymbol_r(symD), .extFaultHold_r(hold),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial forever #5 core_clk = ~core_clk;
  // ****************
  // shared tasks
  // ****************
  function [11:0] symv(input [5:0] x);
    symv = {x, ~x};
  endfunction
  task giveVerdict;
    begin
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      nCompared = nCompared + 1;
      if (seen !== exp) begin
        errorCnt = errorCnt + 1;
        $display("Error %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task stall;
    begin
      errorCnt = errorCnt + 1;
      $display("Error %0t: bus answer never came", $time);
      giveVerdict;
    end
  endtask
  task automatic axw(input [11:0] a, input [31:0] d, input [1:0] er);
    integer i;
    begin
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
        @(posedge core_clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) break;
      end
      bready <= 1'b0;
      if (i == 40) stall();
      check(32'(bresp), 32'(er));
    end
  endtask
  task automatic axr(input [11:0] a, input [31:0] d, input [31:0] m, input [1:0] er);
    integer i;
    begin
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
        @(posedge core_clk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) break;
      end
      rready <= 1'b0;
      if (i == 40) stall();
      check(rdata & m, d);
      check(32'(rresp), 32'(er));
    end
  endtask
  // ****************
  // predictor and monitor
  // ****************
  always @(posedge core_clk) begin
    if (!resetn) begin
      {e1, e2, e3, e4, persist} = 5'h00;
      hc = 0;
    end else begin
      csr = e2 & !txEnable;
      nt.k = `ROW_NORMAL;
      if (txEnable & e2 & txError) nt.k = `ROW_XMT_ERR;
      else if (csr & persist) nt.k = `ROW_CSEXT_ERR;
      else if (csr & !txError) nt.k = `ROW_CSRESET;
      else if (csr) nt.k = (txData == `EXT_OCTET) ? `ROW_CSEXT : `ROW_CSEXT_ERR;
      persist = csr & e1 & (nt.k == `ROW_CSEXT_ERR);
      ce = txError & !txEnable & (txData != `EXT_OCTET) & !ctrlVal[`CTRL_LPI_BIT];
      nt.h = persist | (hc != 0);
      hc = persist ? 3 : (hc > 0) ? hc - 1 : 0;
      sz = (ctrlVal[1:0] == `MODE_SEND_Z);
      nt.known = sz & !e2 & !e3;
      nt.m = !sz ? 9'h000 : e2 ? 9'h00F : {!e3, 8'hFF};
      nt.w = e2 ? {5'h00, txData[3:0]} : {7'h00, ce, ce};
      if (chk) notes.push_back(nt);
      {e4, e3, e2, e1} = {e3, e2, e1, txEnable};
    end
  end
  always @(negedge core_clk) begin
    if (notes.size() > 0) begin
      got = notes.pop_front();
      check(32'(kind), 32'(got.k));
      if (got.m != 9'h000) check(32'(word & got.m), 32'(got.w & got.m));
      check(32'(hold), 32'(got.h));
      if (got.k != `ROW_NORMAL) check(32'(sym), 32'(symv(6'(got.k))));
      else if (got.known) check(32'(sym), 32'(symv(6'h08 + got.w[5:0])));
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    axr(`CTRL_OFS, 32'h0000_0004, 32'hFFFF_FFFF, `RESP_OKAY);
    axr(12'h008, 32'h0000_0000, 32'hFFFF_FFFF, `RESP_SLVERR);
    axw(`STATUS_OFS, 32'h0000_0001, `RESP_SLVERR);
    for (t = 1; t < 5; t++)
      for (j = 0; j < 8; j++)
        axw(`SUB_TBL_BASE + 12'((t - 1) * 32 + j * 4), 32'(symv(6'(t))), `RESP_OKAY);
    axw(`NORM_TBL_BASE, 32'(symv(6'h08)), `RESP_OKAY);
    axw(`NORM_TBL_BASE + 12'h00C, 32'(symv(6'h0B)), `RESP_OKAY);
    axr(`NORM_TBL_BASE + 12'h00C, 32'(symv(6'h0B)), 32'h0000_0FFF, `RESP_OKAY);
    $display("test setup done");
    for (t = 0; t < 5; t++) begin
      run <= 1'b0;
      chk <= 1'b0;
      repeat (6) @(posedge core_clk);
      axr(`STATUS_OFS, 32'h0000_0000, 32'h0000_0007, `RESP_OKAY);
      axw(`CTRL_OFS, 32'(modes[t]), `RESP_OKAY);
      axr(`CTRL_OFS, 32'(modes[t]), 32'h0000_003F, `RESP_OKAY);
      ctrlVal <= modes[t];
      chk <= 1'b1;
      run <= 1'b1;
      repeat (400) @(posedge core_clk);
      $display("test mode %h done", modes[t]);
    end
    giveVerdict;
  end
endmodule // gbit_pcs_tx_trellis_mapper_test
